// ### pkg/rtc_pkg.sv
/*
 * Constants shared by the real-time clock target: register offsets,
 * field positions, reset values, bus address and timing.
 * Assumes a single 50 MHz system clock.
 */
package rtc_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [2:0] REG_SECONDS  = 3'h0;
    localparam logic [2:0] REG_MINUTES  = 3'h1;
    localparam logic [2:0] REG_HOURS    = 3'h2;
    localparam logic [2:0] REG_WEEKDAY  = 3'h3;
    localparam logic [2:0] REG_DATE     = 3'h4;
    localparam logic [2:0] REG_MONTH    = 3'h5;
    localparam logic [2:0] REG_YEAR     = 3'h6;
    localparam logic [2:0] REG_CONTROL  = 3'h7;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_HALT          = 7;
    localparam int BIT_CENT_ALLOW    = 7;
    localparam int BIT_CENTURY       = 6;
    localparam int BIT_OUT_LEVEL     = 7;
    localparam int BIT_FREQ_TEST     = 6;
    localparam int BIT_CAL_SIGN      = 5;
    localparam int CAL_MSB           = 4;
    // ----------------------------------------------------------------
    // Field masks and limits (BCD)
    // ----------------------------------------------------------------
    localparam logic [7:0] MASK_SECONDS = 8'h7F;
    localparam logic [7:0] MASK_MINUTES = 8'h7F;
    localparam logic [7:0] MASK_HOURS   = 8'h3F;
    localparam logic [7:0] MASK_WEEKDAY = 8'h07;
    localparam logic [7:0] MASK_DATE    = 8'h3F;
    localparam logic [7:0] MASK_MONTH   = 8'h1F;
    localparam logic [7:0] MAX_SEC_MIN  = 8'h59;
    localparam logic [7:0] MAX_HOURS    = 8'h23;
    localparam logic [7:0] MAX_WEEKDAY  = 8'h07;
    localparam logic [7:0] MAX_MONTH    = 8'h12;
    localparam logic [7:0] MAX_YEAR     = 8'h99;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] RST_ONE      = 8'h01;
    localparam logic [7:0] RST_CONTROL  = 8'h80;
    // ----------------------------------------------------------------
    // Bus address and timing
    // ----------------------------------------------------------------
    localparam logic [7:0] I2C_ADDR_BYTE   = 8'hD0;
    localparam int         CLK_HZ          = 50_000_000;
    localparam int         SECOND_S        = 1;
    localparam int         FREQ_TEST_HZ    = 512;
    localparam int         CAL_STEP_CYCLES = 1;
endpackage : rtc_pkg

// ### verilog/rtc_bcd_cnt.sv
/*
 * Two-digit BCD counter with load, wrap from max to min and a carry.
 * Assumes load and inc come from logic on sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module rtc_bcd_cnt
    import rtc_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       inc,
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    input  wire logic [7:0] min_val,
    input  wire logic [7:0] max_val,
    output logic      [7:0] value,
    output logic            wrap
);
    logic [7:0] next_value;

    assign wrap = inc && !load && (value >= max_val);

    always_comb begin
        next_value = value;
        if (load) begin
            next_value = load_val;
        end else if (inc) begin
            if (value >= max_val) begin
                next_value = min_val;
            end else if (value[3:0] >= 4'h9) begin
                next_value = {value[7:4] + 4'h1, 4'h0};
            end else begin
                next_value = value + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            value <= RESET_VAL;
        end else begin
            value <= next_value;
        end
    end
endmodule : rtc_bcd_cnt
`default_nettype wire

// ### verilog/rtc_top.sv
/*
 * Battery-backed real-time clock reached as a target on a two-wire bus.
 * Assumes scl, sda_in and supply_low are asynchronous pins; sda is open
 * drain and the board resolves it from sda_drive_n.
 */
// Overview of operation
// (R1) Registers are read and written only through bus transfers in which this block is the target.
// (R2) The block answers only the address bytes 0xD0 (write) and 0xD1 (read) and ignores every other address.
// (R3) The hours register carries the century-toggle allow bit in D7 and the century flag in D6.
// (R4) The control register holds output level in D7, frequency test in D6, calibration sign in D5 and magnitude below.
// (R5) After a low-supply halt the clock stays stopped until seconds, minutes and hours are all rewritten.
// (R6) Bytes 0 to 6 hold BCD seconds with halt flag, minutes, hours, weekday, date, month and year.
`timescale 1ns/10ps
`default_nettype none
module rtc_top
    import rtc_pkg::*;
#(
    parameter int CYCLES_PER_SECOND = CLK_HZ * SECOND_S
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic scl,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_drive_n,
    input  wire logic supply_low,
    output logic      clock_out
);
    localparam int FT_HALF = CYCLES_PER_SECOND / (2 * FREQ_TEST_HZ);

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_ACK   = 3'b010,
        ST_WRITE = 3'b011,
        ST_READ  = 3'b100,
        ST_RACK  = 3'b101
    } rtc_state_type;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q, low_m, low_s;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            {scl_m, scl_s, scl_q} <= 3'h7;
            {sda_m, sda_s, sda_q} <= 3'h7;
            {low_m, low_s}        <= 2'h0;
        end else begin
            {scl_m, scl_s, scl_q} <= {scl, scl_m, scl_s};
            {sda_m, sda_s, sda_q} <= {sda_in, sda_m, sda_s};
            {low_m, low_s}        <= {supply_low, low_m};
        end
    end
    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = scl_s && !scl_q;
    assign scl_fall  = !scl_s && scl_q;
    assign bus_start = scl_s && scl_q && sda_q && !sda_s;
    assign bus_stop  = scl_s && scl_q && !sda_q && sda_s;

    // ----------------------------------------------------------------
    // Bus target state
    // ----------------------------------------------------------------
    rtc_state_type state, next_state;
    logic [7:0] shift, next_shift, wr_data, next_wr_data, rd_byte;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [2:0] ptr, next_ptr, wr_ptr, next_wr_ptr;
    logic       rw, next_rw, ptr_set, next_ptr_set, drive, next_drive;
    logic       wr_stb, next_wr_stb;

    // Time and control state
    logic [7:0] sec_val, min_val, hour_val, day_val, date_val, mon_val, year_val;
    logic [7:0] ctrl, next_ctrl, month_len;
    logic       halt, next_halt, lv_halt, next_lv_halt;
    logic       cent_allow, next_cent_allow, century, next_century;
    logic [2:0] rewritten, next_rewritten;

    always_comb begin
        case (ptr)
            REG_SECONDS: rd_byte = {halt, sec_val[6:0]};                      // [R6]
            REG_MINUTES: rd_byte = min_val;
            REG_HOURS:   rd_byte = {cent_allow, century, hour_val[5:0]};      // [R3]
            REG_WEEKDAY: rd_byte = day_val;
            REG_DATE:    rd_byte = date_val;
            REG_MONTH:   rd_byte = mon_val;
            REG_YEAR:    rd_byte = year_val;
            default:     rd_byte = ctrl;                                      // [R4]
        endcase
    end

    // Data bits change only after scl falls, so a start or stop is never faked
    always_comb begin
        next_state   = state;
        next_shift   = shift;
        next_bit_cnt = bit_cnt;
        next_ptr     = ptr;
        next_rw      = rw;
        next_ptr_set = ptr_set;
        next_drive   = drive;
        next_wr_stb  = 1'b0;
        next_wr_data = wr_data;
        next_wr_ptr  = wr_ptr;
        if (bus_start) begin
            next_state   = ST_ADDR;
            next_bit_cnt = 4'h0;
            next_drive   = 1'b0;
            next_ptr_set = 1'b0;
        end else if (bus_stop) begin
            next_state = ST_IDLE;
            next_drive = 1'b0;
        end else begin
            case (state)
                ST_ADDR: begin
                    if (scl_rise) begin
                        next_shift   = {shift[6:0], sda_s};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        if (shift[7:1] == I2C_ADDR_BYTE[7:1]) begin              // [R2]
                            next_state = ST_ACK;
                            next_drive = 1'b1;
                            next_rw    = shift[0];
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        if (rw) begin
                            next_state = ST_READ;
                            next_shift = rd_byte;
                            next_drive = !rd_byte[7];
                            next_ptr   = ptr + 3'h1;
                        end else begin
                            next_state = ST_WRITE;
                            next_drive = 1'b0;
                        end
                    end
                end
                ST_WRITE: begin
                    if (scl_rise) begin
                        next_shift   = {shift[6:0], sda_s};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        next_state = ST_ACK;
                        next_drive = 1'b1;
                        if (!ptr_set) begin
                            next_ptr     = shift[2:0];
                            next_ptr_set = 1'b1;
                        end else begin
                            next_wr_stb  = 1'b1;                                  // [R1]
                            next_wr_data = shift;
                            next_wr_ptr  = ptr;
                            next_ptr     = ptr + 3'h1;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_rise) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt == 4'h8) begin
                            next_state = ST_RACK;
                            next_drive = 1'b0;
                        end else begin
                            next_shift = {shift[6:0], 1'b0};
                            next_drive = !shift[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise && sda_s) begin
                        next_state = ST_IDLE;
                    end else if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        next_state   = ST_READ;
                        next_shift   = rd_byte;
                        next_drive   = !rd_byte[7];
                        next_ptr     = ptr + 3'h1;
                    end
                end
                default: begin
                    next_drive = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state   <= ST_IDLE;
            shift   <= 8'h00;
            bit_cnt <= 4'h0;
            ptr     <= REG_SECONDS;
            rw      <= 1'b0;
            ptr_set <= 1'b0;
            drive   <= 1'b0;
            wr_stb  <= 1'b0;
            wr_data <= 8'h00;
            wr_ptr  <= REG_SECONDS;
        end else begin
            state   <= next_state;
            shift   <= next_shift;
            bit_cnt <= next_bit_cnt;
            ptr     <= next_ptr;
            rw      <= next_rw;
            ptr_set <= next_ptr_set;
            drive   <= next_drive;
            wr_stb  <= next_wr_stb;
            wr_data <= next_wr_data;
            wr_ptr  <= next_wr_ptr;
        end
    end
    assign sda_out     = 1'b0;
    assign sda_drive_n = !drive;

    // ----------------------------------------------------------------
    // Timebase with calibration trim
    // ----------------------------------------------------------------
    logic [31:0] presc, next_presc, period;
    logic [31:0] ft_cnt, next_ft_cnt;
    logic        ft_wave, next_ft_wave, tick, running, ld_sec;
    assign ld_sec  = wr_stb && wr_ptr == REG_SECONDS;
    assign period  = ctrl[BIT_CAL_SIGN]
                   ? 32'(CYCLES_PER_SECOND - int'(ctrl[CAL_MSB:0]) * CAL_STEP_CYCLES)
                   : 32'(CYCLES_PER_SECOND + int'(ctrl[CAL_MSB:0]) * CAL_STEP_CYCLES);
    assign tick    = presc >= period - 32'h1;
    assign running = !halt && !lv_halt;                                       // [R5]

    always_comb begin
        next_presc   = (tick || ld_sec || !running) ? 32'h0 : presc + 32'h1;
        next_ft_cnt  = ft_cnt + 32'h1;
        next_ft_wave = ft_wave;
        if (ft_cnt >= 32'(FT_HALF - 1)) begin
            next_ft_cnt  = 32'h0;
            next_ft_wave = !ft_wave;
        end
    end

    // ----------------------------------------------------------------
    // Calendar chain
    // ----------------------------------------------------------------
    logic sec_wrap, min_wrap, hour_wrap, date_wrap, mon_wrap, year_wrap;
    logic sec_inc, leap;
    assign sec_inc = tick && running;
    // BCD years divisible by four: tens even with units 0/4/8, tens odd with 2/6
    assign leap = year_val[4] ? (year_val[3:0] == 4'h2 || year_val[3:0] == 4'h6)
                              : (year_val[3:0] == 4'h0 || year_val[3:0] == 4'h4
                                 || year_val[3:0] == 4'h8);
    always_comb begin
        case (mon_val)
            8'h02:                      month_len = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default:                    month_len = 8'h31;
        endcase
    end

    rtc_bcd_cnt #(.RESET_VAL(RST_ZERO)) u_sec (                               // [R6]
        .sys_clk(sys_clk), .sys_rst(sys_rst), .inc(sec_inc), .load(ld_sec),
        .load_val(wr_data & MASK_SECONDS), .min_val(RST_ZERO),
        .max_val(MAX_SEC_MIN), .value(sec_val), .wrap(sec_wrap));
    rtc_bcd_cnt #(.RESET_VAL(RST_ZERO)) u_min (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .inc(sec_wrap),
        .load(wr_stb && wr_ptr == REG_MINUTES), .load_val(wr_data & MASK_MINUTES),
        .min_val(RST_ZERO), .max_val(MAX_SEC_MIN), .value(min_val), .wrap(min_wrap));
    rtc_bcd_cnt #(.RESET_VAL(RST_ZERO)) u_hour (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .inc(min_wrap),
        .load(wr_stb && wr_ptr == REG_HOURS), .load_val(wr_data & MASK_HOURS),
        .min_val(RST_ZERO), .max_val(MAX_HOURS), .value(hour_val), .wrap(hour_wrap));
    rtc_bcd_cnt #(.RESET_VAL(RST_ONE)) u_day (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .inc(hour_wrap),
        .load(wr_stb && wr_ptr == REG_WEEKDAY), .load_val(wr_data & MASK_WEEKDAY),
        .min_val(RST_ONE), .max_val(MAX_WEEKDAY), .value(day_val), .wrap());
    rtc_bcd_cnt #(.RESET_VAL(RST_ONE)) u_date (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .inc(hour_wrap),
        .load(wr_stb && wr_ptr == REG_DATE), .load_val(wr_data & MASK_DATE),
        .min_val(RST_ONE), .max_val(month_len), .value(date_val), .wrap(date_wrap));
    rtc_bcd_cnt #(.RESET_VAL(RST_ONE)) u_mon (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .inc(date_wrap),
        .load(wr_stb && wr_ptr == REG_MONTH), .load_val(wr_data & MASK_MONTH),
        .min_val(RST_ONE), .max_val(MAX_MONTH), .value(mon_val), .wrap(mon_wrap));
    rtc_bcd_cnt #(.RESET_VAL(RST_ZERO)) u_year (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .inc(mon_wrap),
        .load(wr_stb && wr_ptr == REG_YEAR), .load_val(wr_data),
        .min_val(RST_ZERO), .max_val(MAX_YEAR), .value(year_val), .wrap(year_wrap));

    // ----------------------------------------------------------------
    // Halt, century and control bits
    // ----------------------------------------------------------------
    always_comb begin
        next_halt       = halt;
        next_cent_allow = cent_allow;
        next_century    = century;
        next_ctrl       = ctrl;
        next_rewritten  = rewritten;
        next_lv_halt    = lv_halt;
        if (year_wrap && cent_allow) begin
            next_century = !century;                                          // [R3]
        end
        if (wr_stb) begin
            case (wr_ptr)
                REG_SECONDS: begin
                    next_halt         = wr_data[BIT_HALT];
                    next_rewritten[0] = 1'b1;
                end
                REG_MINUTES: next_rewritten[1] = 1'b1;
                REG_HOURS: begin
                    next_cent_allow   = wr_data[BIT_CENT_ALLOW];              // [R3]
                    next_century      = wr_data[BIT_CENTURY];
                    next_rewritten[2] = 1'b1;
                end
                REG_CONTROL: next_ctrl = wr_data;                             // [R4]
                default: next_ctrl = ctrl;
            endcase
        end
        // Low supply wins over a rewrite landing in the same cycle
        if (low_s) begin
            next_lv_halt   = 1'b1;                                            // [R5]
            next_rewritten = 3'h0;
        end else if (lv_halt && next_rewritten == 3'h7) begin
            next_lv_halt = 1'b0;                                              // [R5]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            presc      <= 32'h0;
            ft_cnt     <= 32'h0;
            ft_wave    <= 1'b0;
            halt       <= 1'b0;
            lv_halt    <= 1'b0;
            rewritten  <= 3'h0;
            cent_allow <= 1'b0;
            century    <= 1'b0;
            ctrl       <= RST_CONTROL;
            clock_out  <= 1'b1;
        end else begin
            presc      <= next_presc;
            ft_cnt     <= next_ft_cnt;
            ft_wave    <= next_ft_wave;
            halt       <= next_halt;
            lv_halt    <= next_lv_halt;
            rewritten  <= next_rewritten;
            cent_allow <= next_cent_allow;
            century    <= next_century;
            ctrl       <= next_ctrl;
            clock_out  <= ctrl[BIT_FREQ_TEST] ? ft_wave : ctrl[BIT_OUT_LEVEL];     // [R4]
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_idle_no_drive: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R1]
        (state == ST_IDLE) |-> !drive) else $error("sda driven while idle");
    a_addr_mismatch: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R2]
        (state == ST_ADDR && scl_fall && bit_cnt == 4'h8 && !bus_start && !bus_stop
         && shift[7:1] != I2C_ADDR_BYTE[7:1]) |=> (state == ST_IDLE && !drive))
        else $error("foreign address acknowledged");
    a_hours_century: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R3]
        (state == ST_ACK && rw && scl_fall && !bus_start && !bus_stop && ptr == REG_HOURS)
        |=> shift == {$past(cent_allow), $past(century), $past(hour_val[5:0])})
        else $error("hours read lacks century bits");
    a_control_read: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R4]
        (state == ST_ACK && rw && scl_fall && !bus_start && !bus_stop && ptr == REG_CONTROL)
        |=> shift == $past(ctrl)) else $error("control read mismatch");
    a_halt_holds: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R5]
        (lv_halt && !wr_stb) |=> $stable(sec_val) && presc == 32'h0)
        else $error("clock ran during low-supply halt");
    a_seconds_bcd: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R6]
        ($past(sec_inc) && $past(sec_val) == MAX_SEC_MIN && !$past(ld_sec))
        |-> sec_val == RST_ZERO ##0 sec_val <= MAX_SEC_MIN)
        else $error("seconds left BCD range");
endmodule : rtc_top
`default_nettype wire

// ### tb/rtc_i2c_host.sv
/*
 * Bus master model that stands in for the host's two-wire controller.
 * Assumes the bench resolves the open-drain data line with a pull-up.
 */
`timescale 1ns/10ps
`default_nettype none
module rtc_i2c_host (
    input  wire logic sys_clk,
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda_line
);
    // ----------------------------------------------------------------
    // Bus phases, each held five system clocks
    // ----------------------------------------------------------------
    initial begin
        scl     = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic gap();
        repeat (5) @(negedge sys_clk);
    endtask : gap
    task automatic start();
        sda_rel = 1'b1;
        scl     = 1'b1;
        gap();
        sda_rel = 1'b0;
        gap();
        scl = 1'b0;
        gap();
    endtask : start
    task automatic stop();
        sda_rel = 1'b0;
        gap();
        scl = 1'b1;
        gap();
        sda_rel = 1'b1;
        gap();
    endtask : stop
    // Data only moves while scl is low, so no false start or stop
    task automatic bit_io(input logic b, output logic r);
        sda_rel = b;
        gap();
        scl = 1'b1;
        gap();
        r   = sda_line;
        scl = 1'b0;
        gap();
    endtask : bit_io
    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ack_in, ack);
    endtask : xfer
endmodule : rtc_i2c_host
`default_nettype wire

// ### tb/rtc_top_test.sv
/*
 * Self-checking bench for the clock target: rows, then hand tests.
 * Assumes the partner model drives the bus and a pull-up on data.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module rtc_top_test;
    import rtc_pkg::*;
    logic        sys_clk, sys_rst, scl, sda_rel, sda_in, sda_out, sda_drive_n;
    logic        supply_low, clock_out, ack, ft_prev;
    logic [7:0]  b;
    logic [63:0] q;
    int          mismatches, compares;
    // Pointer, written byte, expected read-back
    localparam logic [23:0] ROWS [8] = '{24'h00_35_35, 24'h01_D9_59, 24'h02_E3_E3,
        24'h03_FD_05, 24'h04_F1_31, 24'h05_F2_12, 24'h06_99_99, 24'h07_25_25};
    assign sda_in = sda_rel & (sda_drive_n | sda_out);
    rtc_top #(.CYCLES_PER_SECOND(2048)) rtc_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_drive_n(sda_drive_n),
        .supply_low(supply_low), .clock_out(clock_out));
    rtc_i2c_host rtc_i2c_host_i (.sys_clk(sys_clk), .scl(scl), .sda_rel(sda_rel),
        .sda_line(sda_in));
    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] p, input logic [23:0] d, input int n);
        rtc_i2c_host_i.start();
        rtc_i2c_host_i.xfer(I2C_ADDR_BYTE, 1'b1, b, ack);
        `CHK(ack, 1'b0)
        rtc_i2c_host_i.xfer(p, 1'b1, b, ack);
        for (int i = n - 1; i >= 0; i--) begin
            rtc_i2c_host_i.xfer(d[8*i +: 8], 1'b1, b, ack);
        end
        rtc_i2c_host_i.stop();
    endtask : wr
    // Pointer set, then a repeated start for the read
    task automatic rd(input logic [7:0] p, input int n);
        rtc_i2c_host_i.start();
        rtc_i2c_host_i.xfer(I2C_ADDR_BYTE, 1'b1, b, ack);
        rtc_i2c_host_i.xfer(p, 1'b1, b, ack);
        rtc_i2c_host_i.start();
        rtc_i2c_host_i.xfer(I2C_ADDR_BYTE | 8'h01, 1'b1, b, ack);
        q = '0;
        for (int i = 0; i < n; i++) begin
            rtc_i2c_host_i.xfer(8'hFF, (i == n - 1), b, ack);
            q = {q[55:0], b};
        end
        rtc_i2c_host_i.stop();
    endtask : rd
    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #(20 * 60000);
        mismatches++;
        tally_and_finish();
    end
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        sys_rst    = 1'b1;
        supply_low = 1'b0;
        mismatches = 0;
        compares   = 0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (5) @(negedge sys_clk);
        `CHK(clock_out, 1'b1)
        rd(8'h00, 8);
        `CHK(q, 64'h00000001_01010080)
        $display("reset values done");
        foreach (ROWS[r]) begin
            wr(ROWS[r][23:16], {16'h0, ROWS[r][15:8]}, 1);
            rd(ROWS[r][23:16], 1);
            `CHK(q[7:0], ROWS[r][7:0])
        end
        `CHK(clock_out, 1'b0)
        $display("register rows done");
        // Pointer wraps from control back to seconds
        wr(8'h07, 24'h80_42, 2);
        rd(8'h07, 2);
        `CHK(q[15:0], 16'h8042)
        `CHK(clock_out, 1'b1)
        rtc_i2c_host_i.start();
        rtc_i2c_host_i.xfer(8'hD2, 1'b1, b, ack);
        rtc_i2c_host_i.stop();
        `CHK(ack, 1'b1)
        // Frequency test with 2048 cycles a second gives a half period of 2 clocks
        wr(8'h07, 24'h40, 1);
        ft_prev = clock_out;
        repeat (2) @(negedge sys_clk);
        `CHK(clock_out, !ft_prev)
        repeat (2) @(negedge sys_clk);
        `CHK(clock_out, ft_prev)
        $display("wrap and foreign address done");
        // Seconds alone do not restart a clock halted by low supply
        supply_low = 1'b1;
        repeat (10) @(negedge sys_clk);
        supply_low = 1'b0;
        wr(8'h00, 24'h10, 1);
        repeat (3000) @(negedge sys_clk);
        rd(8'h00, 1);
        `CHK(q[6:0], 7'h10)
        // Full rewrite restarts it; seconds at 59 must roll into the next minute
        wr(8'h00, 24'h59_00_00, 3);
        repeat (2100) @(negedge sys_clk);
        rd(8'h00, 2);
        `CHK(q[15:8], 8'h00)
        `CHK(q[7:0], 8'h01)
        $display("low supply done");
        tally_and_finish();
    end
endmodule : rtc_top_test
`default_nettype wire
